// *** bench/srcs_bus_checker.sv ***
// concurrent checks on the bus between host end and device end
`timescale 1ns/1ps
module srcs_bus_checker (
  input wire logic clock,
  input wire logic srst,
  input wire logic cycValid,
  input wire logic cycWrite,
  input wire logic byteMode,
  input wire logic [srcs_pkg::ADDR_W-1:0] cycAddr,
  input wire logic [srcs_pkg::DATA_W-1:0] cycData,
  input wire logic rspValid,
  input wire logic [srcs_pkg::DATA_W-1:0] rspData
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  logic isWrite;
  logic [srcs_pkg::OFS_W-1:0] ofs;
  logic [srcs_pkg::OFS_W-1:0] u1;
  logic [srcs_pkg::OFS_W-1:0] u2;
  assign isWrite = cycValid && cycWrite;
  assign ofs = cycAddr[srcs_pkg::OFS_W-1:0];
  assign u1 = byteMode ? srcs_pkg::UNLOCK1_BYTE : srcs_pkg::UNLOCK1_WORD;
  assign u2 = byteMode ? srcs_pkg::UNLOCK2_BYTE : srcs_pkg::UNLOCK2_WORD;

  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_read;
    cycValid && !cycWrite;
  endsequence
  sequence s_load_open;
    isWrite && cycData[7:0] == srcs_pkg::CMD_BUFFER_LOAD && ofs == u1;
  endsequence
  sequence s_load_count;
    isWrite && ofs == u2;
  endsequence

  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_read_answer: assert property (s_read |=> rspValid)
    else $error("read cycle got no answer one cycle later");
  a_rsp_cause: assert property (rspValid |-> $past(cycValid && !cycWrite))
    else $error("answer without a read cycle before it");
  a_rsp_pulse: assert property (rspValid |=> !rspValid)
    else $error("answer valid longer than one cycle");
  a_rsp_hold: assert property (!rspValid |-> $stable(rspData))
    else $error("read data moved without an answer");
  a_write_gap: assert property (isWrite |=> !cycValid)
    else $error("no idle cycle after a write cycle");
  a_load_steps: assert property (s_load_open |-> ##2 s_load_count)
    else $error("load code not followed by second unlock write");
  a_load_sector: assert property (s_load_open ##2 s_load_count |->
      ##2 (isWrite && cycAddr[19:12] == $past(cycAddr[19:12], 4)))
    else $error("load data left the starting sector");
  a_reset_quiet: assert property ($fell(srst) |-> !cycValid [*2])
    else $error("bus cycle too soon after reset release");
endmodule : srcs_bus_checker

// *** bench/tb.sv ***
// self-checking bench joining host end and device end across the bus
`timescale 1ns/1ps
module tb;
  logic clock, srst, cmdValid, byteModeSel, cmdReady, wordTake, done;
  logic [2:0] cmdOp;
  logic [7:0] cmdSector;
  logic [11:0] cmdOffset;
  logic [4:0] cmdCount;
  logic [15:0] cmdData, readData, configRegister, arrayData, lockRegisterValue;
  logic allBanksIdle, programSuspended, eraseSuspended, modeRegion, modeLock, modeUnknown;
  logic programResume, eraseResume, blankCheckStart, commitDone;
  int badCount, checkCount, cycles, commits, strays;
  int progs, erases, blanks;

  srcs_bus_if u_srcs_bus_if ();
  srcs_host u_srcs_host (.clock(clock), .srst(srst), .bus(u_srcs_bus_if), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .byteModeSel(byteModeSel), .cmdSector(cmdSector), .cmdOffset(cmdOffset),
    .cmdCount(cmdCount), .cmdData(cmdData), .cmdReady(cmdReady), .wordTake(wordTake),
    .done(done), .readData(readData));
  srcs_device u_srcs_device (.clock(clock), .srst(srst), .bus(u_srcs_bus_if),
    .allBanksIdle(allBanksIdle), .programSuspended(programSuspended),
    .eraseSuspended(eraseSuspended), .configRegister(configRegister), .arrayData(arrayData),
    .modeRegion(modeRegion), .modeLock(modeLock), .modeUnknown(modeUnknown),
    .programResume(programResume), .eraseResume(eraseResume),
    .blankCheckStart(blankCheckStart), .commitDone(commitDone),
    .lockRegisterValue(lockRegisterValue));
  srcs_bus_checker u_srcs_bus_checker (.clock(clock), .srst(srst),
    .cycValid(u_srcs_bus_if.cycValid), .cycWrite(u_srcs_bus_if.cycWrite),
    .byteMode(u_srcs_bus_if.byteMode), .cycAddr(u_srcs_bus_if.cycAddr),
    .cycData(u_srcs_bus_if.cycData), .rspValid(u_srcs_bus_if.rspValid),
    .rspData(u_srcs_bus_if.rspData));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one user operation on the host end; next data word follows each word take
  task automatic run_op(input logic [2:0] op, input logic bsel, input logic [7:0] sec,
      input logic [11:0] ofs, input logic [4:0] cnt, input logic [15:0] d0);
    int n;
    int k;
    n = 0;
    k = 0;
    @(negedge clock);
    while (cmdReady !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    cmdValid <= 1'b1;
    cmdOp <= op;
    byteModeSel <= bsel;
    cmdSector <= sec;
    cmdOffset <= ofs;
    cmdCount <= cnt;
    cmdData <= d0;
    @(posedge clock);
    cmdValid <= 1'b0;
    n = 0;
    @(negedge clock);
    while (done !== 1'b1 && n < 300) begin
      if (wordTake === 1'b1) begin
        k++;
        @(posedge clock);
        cmdData <= d0 + 16'(k);
      end
      @(negedge clock);
      n++;
    end
    check("done", {15'h0, done}, 16'h0001);
  endtask : run_op

  task automatic rd_chk(input string name, input logic bsel, input logic [11:0] ofs,
      input logic [15:0] exp);
    run_op(3'd3, bsel, 8'h05, ofs, 5'd0, 16'h0000);
    check(name, readData, exp);
  endtask : rd_chk

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("region", {15'h0, modeRegion}, 16'h0000);
    check("lock", {15'h0, modeLock}, 16'h0000);
    check("lockval", lockRegisterValue, 16'hffff);
  endtask : t_reset

  task automatic t_gating();
    run_op(3'd5, 1'b0, 8'h05, 12'h000, 5'd0, 16'h0000);
    run_op(3'd4, 1'b0, 8'h05, 12'h000, 5'd0, 16'h1234);
    check("lockval", lockRegisterValue, 16'hffff);
    check("commits", 16'(commits), 16'h0000);
    check("unknown", {15'h0, modeUnknown}, 16'h0000);
  endtask : t_gating

  task automatic t_busy();
    @(posedge clock);
    allBanksIdle <= 1'b0;
    run_op(3'd1, 1'b0, 8'h05, 12'h000, 5'd0, 16'h0000);
    check("region", {15'h0, modeRegion}, 16'h0000);
    run_op(3'd0, 1'b0, 8'h05, 12'h000, 5'd0, 16'h0000);
    check("lock", {15'h0, modeLock}, 16'h0000);
    @(posedge clock);
    allBanksIdle <= 1'b1;
  endtask : t_busy

  task automatic t_region();
    int i;
    run_op(3'd1, 1'b0, 8'h05, 12'h000, 5'd0, 16'h0000);
    check("region", {15'h0, modeRegion}, 16'h0001);
    run_op(3'd6, 1'b0, 8'h05, 12'h000, 5'd0, 16'h0033);
    check("region", {15'h0, modeRegion}, 16'h0001);
    run_op(3'd4, 1'b0, 8'h05, 12'h003, 5'd3, 16'h5aee);
    check("commits", 16'(commits), 16'h0001);
    for (i = 0; i < 4; i++) begin
      rd_chk("word", 1'b0, 12'h003 + 12'(i), 16'h5aee + 16'(i));
    end
    rd_chk("past_end", 1'b0, 12'h007, 16'hffff);
    rd_chk("gated", 1'b0, 12'h000, 16'hffff);
    rd_chk("byte_rd", 1'b1, 12'h004, 16'h5aef);
    run_op(3'd4, 1'b1, 8'h05, 12'h020, 5'd31, 16'h0100);
    rd_chk("page_lo", 1'b0, 12'h020, 16'h0100);
    rd_chk("page_hi", 1'b0, 12'h03f, 16'h011f);
    run_op(3'd0, 1'b0, 8'h05, 12'h000, 5'd0, 16'h0000);
    check("lock", {15'h0, modeLock}, 16'h0000);
    run_op(3'd2, 1'b0, 8'h05, 12'h000, 5'd0, 16'h0000);
    check("region", {15'h0, modeRegion}, 16'h0000);
    rd_chk("array", 1'b0, 12'h003, 16'h3c3c);
  endtask : t_region

  task automatic t_lock();
    run_op(3'd0, 1'b1, 8'h09, 12'h000, 5'd0, 16'h0000);
    check("lock", {15'h0, modeLock}, 16'h0001);
    rd_chk("lock_rd", 1'b0, 12'h123, 16'hffff);
    run_op(3'd5, 1'b0, 8'h09, 12'h000, 5'd0, 16'h1250);
    check("lockval", lockRegisterValue, 16'h1250);
    rd_chk("lock_rd", 1'b1, 12'h7ff, 16'h1250);
    run_op(3'd2, 1'b0, 8'h09, 12'h000, 5'd0, 16'h0000);
    check("lock", {15'h0, modeLock}, 16'h0000);
  endtask : t_lock

  task automatic t_unknown();
    run_op(3'd1, 1'b0, 8'h02, 12'h000, 5'd0, 16'h0000);
    run_op(3'd4, 1'b0, 8'h02, 12'h0a0, 5'd0, 16'h7777);
    check("unknown", {15'h0, modeUnknown}, 16'h0001);
    rd_chk("unk_rd", 1'b0, 12'h003, 16'h0000);
    run_op(3'd2, 1'b0, 8'h02, 12'h000, 5'd0, 16'h0000);
    check("unknown", {15'h0, modeUnknown}, 16'h0000);
    rd_chk("array", 1'b0, 12'h003, 16'h3c3c);
  endtask : t_unknown

  task automatic t_midreset();
    run_op(3'd1, 1'b0, 8'h05, 12'h000, 5'd0, 16'h0000);
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    check("region", {15'h0, modeRegion}, 16'h0000);
    check("lockval", lockRegisterValue, 16'hffff);
    rd_chk("array", 1'b0, 12'h003, 16'h3c3c);
  endtask : t_midreset

  // one raw side command in normal mode; counts are running totals
  task automatic side_chk(input logic [15:0] cmd, input logic ps, input logic es,
      input logic cb, input int ep, input int ee, input int eb);
    @(posedge clock);
    programSuspended <= ps;
    eraseSuspended <= es;
    configRegister <= {cb, 15'h0000};
    run_op(3'd6, 1'b0, 8'h05, 12'h000, 5'd0, cmd);
    check("prog_resume", 16'(progs), 16'(ep));
    check("erase_resume", 16'(erases), 16'(ee));
    check("blank_check", 16'(blanks), 16'(eb));
  endtask : side_chk

  task automatic t_side();
    side_chk(16'h0050, 1'b0, 1'b1, 1'b1, 0, 0, 0);
    side_chk(16'ha550, 1'b1, 1'b0, 1'b1, 1, 0, 0);
    side_chk(16'h0030, 1'b1, 1'b0, 1'b1, 1, 0, 0);
    side_chk(16'h0030, 1'b0, 1'b1, 1'b1, 1, 1, 0);
    side_chk(16'h0033, 1'b1, 1'b1, 1'b0, 1, 1, 0);
    side_chk(16'h0033, 1'b1, 1'b1, 1'b1, 1, 1, 1);
  endtask : t_side

  // ----------------------------------------
  // clock, monitors, main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (commitDone === 1'b1) commits++;
    if (programResume === 1'b1 || eraseResume === 1'b1 || blankCheckStart === 1'b1) strays++;
    if (programResume === 1'b1) progs++;
    if (eraseResume === 1'b1) erases++;
    if (blankCheckStart === 1'b1) blanks++;
    if (cycles == 20000) begin
      badCount++;
      report_and_stop();
    end
  end

  initial begin
    srst = 1'b1;
    cmdValid = 1'b0;
    cmdOp = 3'h0;
    byteModeSel = 1'b0;
    cmdSector = 8'h00;
    cmdOffset = 12'h000;
    cmdCount = 5'h00;
    cmdData = 16'h0000;
    allBanksIdle = 1'b1;
    programSuspended = 1'b1;
    eraseSuspended = 1'b1;
    configRegister = 16'h8000;
    arrayData = 16'h3c3c;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    t_reset();
    t_gating();
    t_busy();
    t_region();
    t_lock();
    t_midreset();
    t_unknown();
    check("strays", 16'(strays), 16'h0000);
    t_side();
    report_and_stop();
  end
endmodule : tb

// *** src/srcs_bus_if.sv ***
// multiplexed bus cycles between host controller and command sequencer
`timescale 1ns/1ps
interface srcs_bus_if;
  logic cycValid;
  logic cycWrite;
  logic byteMode;
  logic [srcs_pkg::ADDR_W-1:0] cycAddr;
  logic [srcs_pkg::DATA_W-1:0] cycData;
  logic rspValid;
  logic [srcs_pkg::DATA_W-1:0] rspData;

  modport device (
    input cycValid, cycWrite, byteMode, cycAddr, cycData,
    output rspValid, rspData
  );
  modport host (
    output cycValid, cycWrite, byteMode, cycAddr, cycData,
    input rspValid, rspData
  );
endinterface : srcs_bus_if

// *** src/srcs_device.sv ***
// device end: decodes region and lock command sequences, holds region words and lock value
`timescale 1ns/1ps
module srcs_device (
  input wire logic clock,
  input wire logic srst,
  srcs_bus_if.device bus,
  input wire logic allBanksIdle,
  input wire logic programSuspended,
  input wire logic eraseSuspended,
  input wire logic [srcs_pkg::DATA_W-1:0] configRegister,
  input wire logic [srcs_pkg::DATA_W-1:0] arrayData,
  output logic modeRegion,
  output logic modeLock,
  output logic modeUnknown,
  output logic programResume,
  output logic eraseResume,
  output logic blankCheckStart,
  output logic commitDone,
  output logic [srcs_pkg::DATA_W-1:0] lockRegisterValue
);
  typedef enum logic [3:0] {
    S_NORMAL = 4'b0000,
    S_REG_IDLE = 4'b0001,
    S_REG_COUNT = 4'b0011,
    S_REG_DATA = 4'b0010,
    S_REG_CONFIRM = 4'b0110,
    S_LOCK_IDLE = 4'b0100,
    S_LOCK_ZERO = 4'b0101,
    S_LOCK_DATA = 4'b0111,
    S_LOCK_CONFIRM = 4'b1111,
    S_UNKNOWN = 4'b1000
  } srcs_dstate_e;

  srcs_dstate_e state;
  srcs_dstate_e next_state;

  logic [srcs_pkg::DATA_W-1:0] region [srcs_pkg::REGION_WORDS];
  logic [srcs_pkg::DATA_W-1:0] bufWord [srcs_pkg::PAGE_WORDS];
  logic [srcs_pkg::PAGE_WORDS-1:0] bufMask;
  logic [srcs_pkg::IDX_W-1:0] left;
  logic firstWord;
  logic [1:0] page;
  logic [srcs_pkg::SEC_W-1:0] loadSector;
  logic [srcs_pkg::DATA_W-1:0] lockPending;

  logic wr;
  logic rd;
  logic [7:0] code;
  logic [srcs_pkg::SEC_W-1:0] sec;
  logic [srcs_pkg::OFS_W-1:0] ofs;
  logic [srcs_pkg::OFS_W-1:0] wIdx;
  logic atUnlock1;
  logic atUnlock2;
  logic isExit;
  logic dataPhase;
  logic pageOk;

  // --------------------------------------------------------------
  // cycle decode
  // --------------------------------------------------------------
  // reads never decode
  assign wr = bus.cycValid && bus.cycWrite;
  assign rd = bus.cycValid && !bus.cycWrite;
  assign code = bus.cycData[7:0];
  assign sec = bus.cycAddr[srcs_pkg::ADDR_W-1:srcs_pkg::OFS_W];
  assign ofs = bus.cycAddr[srcs_pkg::OFS_W-1:0];
  assign wIdx = srcs_pkg::wordOfs(ofs, bus.byteMode);
  assign atUnlock1 = (ofs == srcs_pkg::unlock1(bus.byteMode));
  assign atUnlock2 = (ofs == srcs_pkg::unlock2(bus.byteMode));
  assign dataPhase = (state == S_REG_DATA) || (state == S_LOCK_DATA);
  assign isExit = wr && !dataPhase && (code == srcs_pkg::CMD_EXIT);
  assign pageOk = firstWord || ((sec == loadSector) && (wIdx[6:5] == page));

  // --------------------------------------------------------------
  // next mode
  // --------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (isExit) begin
      next_state = S_NORMAL;
    end else if (wr) begin
      unique case (state)
        S_NORMAL: begin
          if (allBanksIdle && atUnlock1 && code == srcs_pkg::CMD_LOCK_ENTRY) begin
            next_state = S_LOCK_IDLE;
          end else if (allBanksIdle && atUnlock1 && code == srcs_pkg::CMD_REGION_ENTRY) begin
            next_state = S_REG_IDLE;
          end
        end
        S_REG_IDLE: begin
          if (atUnlock1 && code == srcs_pkg::CMD_BUFFER_LOAD) begin
            next_state = S_REG_COUNT;
          end
        end
        S_REG_COUNT: begin
          if (atUnlock2 && code < 8'(srcs_pkg::PAGE_WORDS)) begin
            next_state = S_REG_DATA;
          end else begin
            next_state = S_UNKNOWN;
          end
        end
        S_REG_DATA: begin
          if (!pageOk || wIdx >= 12'(srcs_pkg::REGION_WORDS)) begin
            next_state = S_UNKNOWN;
          end else if (left == '0) begin
            next_state = S_REG_CONFIRM;
          end
        end
        S_REG_CONFIRM: begin
          next_state = (atUnlock1 && code == srcs_pkg::CMD_BUFFER_COMMIT) ? S_REG_IDLE : S_UNKNOWN;
        end
        S_LOCK_IDLE: begin
          if (atUnlock1 && code == srcs_pkg::CMD_BUFFER_LOAD) begin
            next_state = S_LOCK_ZERO;
          end
        end
        S_LOCK_ZERO: begin
          next_state = (atUnlock2 && code == srcs_pkg::CMD_LOCK_ZERO) ? S_LOCK_DATA : S_UNKNOWN;
        end
        S_LOCK_DATA: begin
          next_state = (ofs == srcs_pkg::LOCK_DATA_OFS) ? S_LOCK_CONFIRM : S_UNKNOWN;
        end
        S_LOCK_CONFIRM: begin
          next_state = (atUnlock1 && code == srcs_pkg::CMD_BUFFER_COMMIT) ? S_LOCK_IDLE : S_UNKNOWN;
        end
        S_UNKNOWN: next_state = S_UNKNOWN;
        default: next_state = S_UNKNOWN;
      endcase
    end
  end

  // --------------------------------------------------------------
  // mode register
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= S_NORMAL;
      modeRegion <= 1'b0;
      modeLock <= 1'b0;
      modeUnknown <= 1'b0;
    end else begin
      state <= next_state;
      modeRegion <= next_state inside {S_REG_IDLE, S_REG_COUNT, S_REG_DATA, S_REG_CONFIRM};
      modeLock <= next_state inside {S_LOCK_IDLE, S_LOCK_ZERO, S_LOCK_DATA, S_LOCK_CONFIRM};
      modeUnknown <= (next_state == S_UNKNOWN);
    end
  end

  // --------------------------------------------------------------
  // write buffer load
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      bufMask <= '0;
      left <= '0;
      firstWord <= 1'b0;
      page <= 2'h0;
      loadSector <= '0;
      lockPending <= '0;
    end else if (wr && state == S_REG_COUNT) begin
      bufMask <= '0;
      left <= code[srcs_pkg::IDX_W-1:0];
      firstWord <= 1'b1;
    end else if (wr && state == S_REG_DATA && pageOk) begin
      // full word kept as program data
      bufWord[wIdx[srcs_pkg::IDX_W-1:0]] <= bus.cycData;
      bufMask[wIdx[srcs_pkg::IDX_W-1:0]] <= 1'b1;
      left <= left - 5'h01;
      firstWord <= 1'b0;
      if (firstWord) begin
        page <= wIdx[6:5];
        loadSector <= sec;
      end
    end else if (wr && state == S_LOCK_DATA) begin
      lockPending <= bus.cycData;
    end
  end

  // --------------------------------------------------------------
  // commit to region and lock value
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    commitDone <= 1'b0;
    if (srst) begin
      for (int i = 0; i < srcs_pkg::REGION_WORDS; i++) begin
        region[i] <= srcs_pkg::ERASED_WORD;
      end
      lockRegisterValue <= srcs_pkg::LOCK_RESET;
    end else if (wr && atUnlock1 && code == srcs_pkg::CMD_BUFFER_COMMIT) begin
      if (state == S_REG_CONFIRM) begin
        for (int i = 0; i < srcs_pkg::PAGE_WORDS; i++) begin
          if (bufMask[i]) begin
            region[{page, 5'(i)}] <= bufWord[i];
          end
        end
        commitDone <= 1'b1;
      end else if (state == S_LOCK_CONFIRM) begin
        lockRegisterValue <= lockPending;
        commitDone <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // normal mode side commands
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    programResume <= 1'b0;
    eraseResume <= 1'b0;
    blankCheckStart <= 1'b0;
    if (!srst && wr && state == S_NORMAL) begin
      programResume <= (code == srcs_pkg::CMD_PROG_RESUME) && programSuspended;
      eraseResume <= (code == srcs_pkg::CMD_ERASE_RESUME) && eraseSuspended;
      blankCheckStart <= (code == srcs_pkg::CMD_BLANK_CHECK) && configRegister[srcs_pkg::CFG_ASYNC_BIT];
    end
  end

  // --------------------------------------------------------------
  // read answers
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      bus.rspValid <= 1'b0;
      bus.rspData <= '0;
    end else begin
      bus.rspValid <= rd;
      if (rd) begin
        if (modeRegion) begin
          bus.rspData <= region[wIdx[srcs_pkg::RIDX_W-1:0]];
        end else if (modeLock) begin
          bus.rspData <= lockRegisterValue;
        end else if (modeUnknown) begin
          bus.rspData <= srcs_pkg::UNKNOWN_READ;
        end else begin
          bus.rspData <= arrayData;
        end
      end
    end
  end
endmodule : srcs_device

// *** src/srcs_host.sv ***
// host controller end: turns user operations into bus cycle sequences
`timescale 1ns/1ps
module srcs_host (
  input wire logic clock,
  input wire logic srst,
  srcs_bus_if.host bus,
  input wire logic cmdValid,
  input wire logic [2:0] cmdOp,
  input wire logic byteModeSel,
  input wire logic [srcs_pkg::SEC_W-1:0] cmdSector,
  input wire logic [srcs_pkg::OFS_W-1:0] cmdOffset,
  input wire logic [srcs_pkg::IDX_W-1:0] cmdCount,
  input wire logic [srcs_pkg::DATA_W-1:0] cmdData,
  output logic cmdReady,
  output logic wordTake,
  output logic done,
  output logic [srcs_pkg::DATA_W-1:0] readData
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_FIRST = 3'b001, H_SECOND = 3'b011, H_DATA = 3'b010,
    H_CONFIRM = 3'b110, H_READ = 3'b111, H_WAIT = 3'b101
  } srcs_hstate_e;

  srcs_hstate_e state;
  logic [2:0] op;
  logic gap;
  logic [srcs_pkg::SEC_W-1:0] sector;
  logic [srcs_pkg::OFS_W-1:0] wofs;
  logic [srcs_pkg::IDX_W-1:0] left;
  logic [srcs_pkg::IDX_W-1:0] room;

  // words that still fit in the page after the start word
  assign room = srcs_pkg::IDX_W'(srcs_pkg::PAGE_WORDS - 1) - cmdOffset[srcs_pkg::IDX_W-1:0];

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_ff @(posedge clock) begin
    bus.cycValid <= 1'b0;
    wordTake <= 1'b0;
    done <= 1'b0;
    if (srst) begin
      state <= H_IDLE;
      op <= 3'h0;
      gap <= 1'b0;
      sector <= '0;
      wofs <= '0;
      left <= '0;
      cmdReady <= 1'b0;
      bus.cycWrite <= 1'b0;
      bus.byteMode <= 1'b0;
      bus.cycAddr <= '0;
      bus.cycData <= '0;
      readData <= '0;
    end else if (gap) begin
      // one idle cycle between bus cycles
      gap <= 1'b0;
    end else begin
      unique case (state)
        H_IDLE: begin
          cmdReady <= 1'b1;
          if (cmdValid && cmdReady) begin
            cmdReady <= 1'b0;
            op <= cmdOp;
            sector <= cmdSector;
            wofs <= cmdOffset;
            left <= (cmdCount > room) ? room : cmdCount;
            bus.byteMode <= byteModeSel;
            state <= (cmdOp == srcs_pkg::OP_READ) ? H_READ : H_FIRST;
          end
        end
        H_FIRST: begin
          bus.cycValid <= 1'b1;
          bus.cycWrite <= 1'b1;
          gap <= 1'b1;
          // op 6 is a raw single write at the given offset, for side commands
          if (op == 3'h6) begin
            bus.cycAddr <= {sector, srcs_pkg::busOfs(wofs, bus.byteMode)};
          end else begin
            bus.cycAddr <= {sector, srcs_pkg::unlock1(bus.byteMode)};
          end
          state <= H_WAIT;
          unique case (op)
            srcs_pkg::OP_ENTER_LOCK: bus.cycData <= {8'h00, srcs_pkg::CMD_LOCK_ENTRY};
            srcs_pkg::OP_ENTER_REGION: bus.cycData <= {8'h00, srcs_pkg::CMD_REGION_ENTRY};
            srcs_pkg::OP_EXIT: bus.cycData <= {8'h00, srcs_pkg::CMD_EXIT};
            3'h6: bus.cycData <= cmdData;
            default: begin
              bus.cycData <= {8'h00, srcs_pkg::CMD_BUFFER_LOAD};
              state <= H_SECOND;
            end
          endcase
        end
        H_SECOND: begin
          bus.cycValid <= 1'b1;
          gap <= 1'b1;
          bus.cycAddr <= {sector, srcs_pkg::unlock2(bus.byteMode)};
          bus.cycData <= (op == srcs_pkg::OP_LOCK_WRITE) ? 16'h0000 : {11'h000, left};
          state <= H_DATA;
        end
        H_DATA: begin
          bus.cycValid <= 1'b1;
          gap <= 1'b1;
          bus.cycData <= cmdData;
          wordTake <= 1'b1;
          if (op == srcs_pkg::OP_LOCK_WRITE) begin
            bus.cycAddr <= {sector, srcs_pkg::LOCK_DATA_OFS};
            state <= H_CONFIRM;
          end else begin
            bus.cycAddr <= {sector, srcs_pkg::busOfs(wofs, bus.byteMode)};
            wofs <= wofs + 12'h001;
            left <= left - 5'h01;
            if (left == '0) begin
              state <= H_CONFIRM;
            end
          end
        end
        H_CONFIRM: begin
          bus.cycValid <= 1'b1;
          gap <= 1'b1;
          bus.cycAddr <= {sector, srcs_pkg::unlock1(bus.byteMode)};
          bus.cycData <= {8'h00, srcs_pkg::CMD_BUFFER_COMMIT};
          state <= H_WAIT;
        end
        H_READ: begin
          bus.cycValid <= 1'b1;
          bus.cycWrite <= 1'b0;
          bus.cycAddr <= {sector, srcs_pkg::busOfs(wofs, bus.byteMode)};
          state <= H_WAIT;
        end
        H_WAIT: begin
          if (bus.cycWrite || bus.rspValid) begin
            if (!bus.cycWrite) begin
              readData <= bus.rspData;
            end
            done <= 1'b1;
            state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule : srcs_host

// *** src/srcs_pkg.sv ***
// shared constants, types and decode helpers for the secure region command sequencer
//
// Functional notes
// - lock mode entry: write 40 to unlock address
// - region mode entry: write 88 to unlock
// - entry accepted only while every bank idle
// - mode commands honoured only inside their mode
// - region load: 25, count, pairs, 29 commits
// - host writes word count as words minus one
// - lock load: 25, 0, data at 00, 29
// - first load address is lowest written word
// - host loads words in ascending address order
// - later addresses stay in same sector, page
// - region mode read returns stored region word
// - lock mode read returns lock register value
// - only read commands use read cycles
// - upper data lane ignored in command cycles
// - host writes reset after a bad sequence
// - F0 write anywhere leaves either mode, except as a data word in the data phase
// - resumes act only while matching suspend holds
// - blank check only with config bit 15 set
package srcs_pkg;
  localparam int ADDR_W = 20;
  localparam int OFS_W = 12;
  localparam int SEC_W = 8;
  localparam int DATA_W = 16;
  localparam int PAGE_WORDS = 32;
  localparam int REGION_WORDS = 128;
  localparam int IDX_W = 5;
  localparam int RIDX_W = 7;

  // command codes, low data byte only
  localparam logic [7:0] CMD_LOCK_ENTRY = 8'h40;
  localparam logic [7:0] CMD_REGION_ENTRY = 8'h88;
  localparam logic [7:0] CMD_BUFFER_LOAD = 8'h25;
  localparam logic [7:0] CMD_BUFFER_COMMIT = 8'h29;
  localparam logic [7:0] CMD_EXIT = 8'hf0;
  localparam logic [7:0] CMD_LOCK_ZERO = 8'h00;
  localparam logic [7:0] CMD_PROG_RESUME = 8'h50;
  localparam logic [7:0] CMD_ERASE_RESUME = 8'h30;
  localparam logic [7:0] CMD_BLANK_CHECK = 8'h33;

  // sector offsets, word and byte addressing
  localparam logic [OFS_W-1:0] UNLOCK1_WORD = 12'h555;
  localparam logic [OFS_W-1:0] UNLOCK1_BYTE = 12'haaa;
  localparam logic [OFS_W-1:0] UNLOCK2_WORD = 12'h2aa;
  localparam logic [OFS_W-1:0] UNLOCK2_BYTE = 12'h554;
  localparam logic [OFS_W-1:0] LOCK_DATA_OFS = 12'h000;

  localparam int CFG_ASYNC_BIT = 15;
  localparam logic [DATA_W-1:0] LOCK_RESET = 16'hffff;
  localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;
  localparam logic [DATA_W-1:0] UNKNOWN_READ = 16'h0000;

  typedef enum logic [2:0] {
    OP_ENTER_LOCK = 3'h0,
    OP_ENTER_REGION = 3'h1,
    OP_EXIT = 3'h2,
    OP_READ = 3'h3,
    OP_REGION_PROGRAM = 3'h4,
    OP_LOCK_WRITE = 3'h5
  } srcs_op_e;

  function automatic logic [OFS_W-1:0] unlock1(input logic byteMode);
    unlock1 = byteMode ? UNLOCK1_BYTE : UNLOCK1_WORD;
  endfunction : unlock1

  function automatic logic [OFS_W-1:0] unlock2(input logic byteMode);
    unlock2 = byteMode ? UNLOCK2_BYTE : UNLOCK2_WORD;
  endfunction : unlock2

  // word index of a bus offset
  function automatic logic [OFS_W-1:0] wordOfs(input logic [OFS_W-1:0] ofs, input logic byteMode);
    wordOfs = byteMode ? {1'b0, ofs[OFS_W-1:1]} : ofs;
  endfunction : wordOfs

  // bus offset of a word index
  function automatic logic [OFS_W-1:0] busOfs(input logic [OFS_W-1:0] ofs, input logic byteMode);
    busOfs = byteMode ? {ofs[OFS_W-2:0], 1'b0} : ofs;
  endfunction : busOfs
endpackage : srcs_pkg
